// File: inc/rot_pkg.sv
// Shared constants and types for the timekeeping core
package rot_pkg;

  // Register index on the serial register port
  localparam logic [4:0] ADDR_SEC = 5'h00;
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam logic [4:0] ADDR_HOUR = 5'h02;
  localparam logic [4:0] ADDR_DAY_OF_WEEK_VALUE = 5'h03;
  localparam logic [4:0] ADDR_DATE = 5'h04;
  localparam logic [4:0] ADDR_MTH = 5'h05;
  localparam logic [4:0] ADDR_YEAR = 5'h06;
  localparam logic [4:0] ADDR_CTRL = 5'h07;
  localparam logic [4:0] ADDR_TOP = 5'h1F;

  // Field positions
  localparam int SEC_START_BIT = 7;
  localparam int HOUR_FMT12_BIT = 6;
  localparam int HOUR_PM_BIT = 5;
  localparam int DAY_OF_WEEK_VALUE_RUN_BIT = 5;
  localparam int DAY_OF_WEEK_VALUE_PFAIL_BIT = 4;
  localparam int DAY_OF_WEEK_VALUE_VBAT_BIT = 3;
  localparam int MTH_LEAP_BIT = 5;
  localparam int CTRL_EXTCLK_BIT = 3;

  // Writable bits per register
  localparam logic [7:0] SEC_WMASK = 8'hFF;
  localparam logic [7:0] MIN_WMASK = 8'h7F;
  localparam logic [7:0] HOUR_WMASK = 8'h7F;
  localparam logic [7:0] DAY_OF_WEEK_VALUE_WMASK = 8'h0F;
  localparam logic [7:0] DATE_WMASK = 8'h3F;
  localparam logic [7:0] MTH_WMASK = 8'h1F;
  localparam logic [7:0] YEAR_WMASK = 8'hFF;
  localparam logic [7:0] CTRL_WMASK = 8'hFF;

  // Reset values
  localparam logic [7:0] SEC_RST = 8'h00;
  localparam logic [7:0] MIN_RST = 8'h00;
  localparam logic [7:0] HOUR_RST = 8'h00;
  localparam logic [7:0] DAY_OF_WEEK_VALUE_RST = 8'h01;
  localparam logic [7:0] DATE_RST = 8'h01;
  localparam logic [7:0] MTH_RST = 8'h01;
  localparam logic [7:0] YEAR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // BCD limits
  localparam logic [6:0] SEC_LAST = 7'h59;
  localparam logic [6:0] MIN_LAST = 7'h59;
  localparam logic [5:0] HOUR24_LAST = 6'h23;
  localparam logic [5:0] HOUR24_FIRST = 6'h00;
  localparam logic [4:0] HOUR12_ELEVEN = 5'h11;
  localparam logic [4:0] HOUR12_TWELVE = 5'h12;
  localparam logic [4:0] HOUR12_ONE = 5'h01;
  localparam logic [2:0] DAY_OF_WEEK_VALUE_LAST = 3'h7;
  localparam logic [2:0] DAY_OF_WEEK_VALUE_FIRST = 3'h1;
  localparam logic [5:0] DATE_FIRST = 6'h01;
  localparam logic [4:0] MTH_LAST = 5'h12;
  localparam logic [4:0] MTH_FIRST = 5'h01;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [5:0] DATE_MAX_31 = 6'h31;
  localparam logic [5:0] DATE_MAX_30 = 6'h30;
  localparam logic [5:0] DATE_MAX_29 = 6'h29;
  localparam logic [5:0] DATE_MAX_28 = 6'h28;
  localparam logic [4:0] MTH_FEB = 5'h02;
  localparam logic [4:0] MTH_APR = 5'h04;
  localparam logic [4:0] MTH_JUN = 5'h06;
  localparam logic [4:0] MTH_SEP = 5'h09;
  localparam logic [4:0] MTH_NOV = 5'h11;

  // Oscillator timing
  localparam int OSC_FREQ_HZ = 32768;
  localparam int OSC_RUN_EDGES = 32;
  localparam int OSC_FAIL_CYCLES_DEF = 1024;
  localparam logic [5:0] OSC_RUN_LAST = 6'(OSC_RUN_EDGES - 1);

  typedef enum logic [1:0] {
    OSC_STOPPED = 2'b00,
    OSC_STARTING = 2'b01,
    OSC_RUNNING = 2'b10
  } rot_osc_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] year;
    logic [7:0] mth;
    logic [7:0] date;
    logic [7:0] day_of_week_value;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rot_regs_t;

endpackage

// File: verilog/rot_month_len.sv
// Month length and leap-year lookup for the calendar
`timescale 1ns/1ns
`default_nettype none
module rot_month_len
  import rot_pkg::*;
(
  input wire logic [4:0] month,     // BCD month 01..12
  input wire logic [7:0] year,      // BCD two-digit year
  output logic leap,                // Year is a leap year
  output logic [5:0] max_date       // BCD last date of the month
);

  // Divisible by four in BCD: even tens with ones 0/4/8, odd tens with 2/6
  always_comb begin
    if (year[4] == 1'b0) begin
      leap = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) || (year[3:0] == 4'h8);
    end else begin
      leap = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
    end
  end

  always_comb begin
    if (month == MTH_FEB) begin
      max_date = leap ? DATE_MAX_29 : DATE_MAX_28; // RULE9
    end else if ((month == MTH_APR) || (month == MTH_JUN) || (month == MTH_SEP) ||
                 (month == MTH_NOV)) begin
      max_date = DATE_MAX_30; // RULE9
    end else begin
      max_date = DATE_MAX_31; // RULE8
    end
  end

endmodule
`default_nettype wire

// File: verilog/rot_core.sv
// Oscillator status and BCD clock/calendar core with buffered register reads
//
// Summary of operation
// (RULE1) Running flag sets after 32 clock edges
// (RULE2) Running flag clears after edge-free timeout
// (RULE3) Disabling the oscillator also drops flag
// (RULE4) Seconds bit 7 starts the oscillator
// (RULE5) Control bit 3 enables external clock
// (RULE6) Host stops clock before loading time
// (RULE7) All fields kept as BCD registers
// (RULE8) Short months and leap years handled
// (RULE9) Month maxima 31, 30, 29 or 28
// (RULE10) Midnight rollover in both formats, carries day
// (RULE11) Weekday 1..7 wraps without carry
// (RULE12) December 31 rolls to January 1, year+1
// (RULE13) Year wraps 99 to 00
// (RULE14) Hours bit 6 selects 12-hour format
// (RULE15) Hours layout: PM bit, tens, ones
// (RULE16) Seconds tens in 6-4, ones 3-0
// (RULE17) Minutes layout, bit 7 reads zero
// (RULE18) Snapshot at read start and address wrap
// (RULE19) Host reads time in one transfer
// (RULE20) Counting never stops on backup supply
// (RULE21) Unimplemented bits read as zero
// (RULE22) Fail timeout is a cycle parameter
`timescale 1ns/1ns
`default_nettype none
module rot_core
  import rot_pkg::*;
#(
  parameter int OSC_FAIL_CYCLES = OSC_FAIL_CYCLES_DEF,
  parameter int EDGES_PER_SEC = OSC_FREQ_HZ
) (
  input wire logic clk,             // System clock, 25 MHz
  input wire logic rst,             // Synchronous reset, active high
  input wire logic ce,              // Clock enable, freezes all state when low
  input wire logic osc_input_pin,   // Oscillator or external clock, asynchronous
  input wire logic pwr_lost,        // Primary power loss event, one cycle
  input wire logic ptr_load,        // Load register pointer
  input wire logic [4:0] ptr_addr,  // Pointer value for ptr_load
  input wire logic rd_begin,        // Read transfer starts
  input wire logic rd_strobe,       // Read one byte at pointer
  input wire logic wr_strobe,       // Write one byte at pointer
  input wire logic [7:0] wr_data,   // Write data
  output logic [7:0] rd_data,       // Read data, valid after rd_strobe
  output logic osc_running_flag,    // Oscillator running status
  output logic sec_tick             // One-cycle pulse per second
);

  localparam int IDLE_W = $clog2(OSC_FAIL_CYCLES + 1);
  localparam int PRE_W = $clog2(EDGES_PER_SEC);
  localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(OSC_FAIL_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(EDGES_PER_SEC - 1);

  logic x1_meta_reg, x1_sync_reg, x1_prev_reg;
  logic [IDLE_W-1:0] idle_reg;
  logic [5:0] edge_cnt_reg;
  logic [PRE_W-1:0] pre_reg;
  rot_osc_state_t osc_state_reg;
  logic [7:0] sec_reg, min_reg, hour_reg, date_reg, mth_reg, year_reg, ctrl_reg;
  logic [3:0] day_of_week_value_reg;
  logic pfail_reg;
  logic [4:0] ptr_reg;
  rot_regs_t snap_reg;
  rot_regs_t live;
  logic osc_en, osc_edge, timed_out;
  logic leap;
  logic [5:0] max_date;
  logic sec_wrap, min_wrap, day_carry, date_wrap, mth_wrap;
  logic [7:0] hour_next;
  logic wr_hit_sec, wr_hit_min, wr_hit_hour, wr_hit_day_of_week_value;
  logic wr_hit_date, wr_hit_mth, wr_hit_year, wr_hit_ctrl;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction

  // Pin crosses into the clk domain through two flops first
  always_ff @(posedge clk) begin
    if (rst) begin
      x1_meta_reg <= 1'b0;
      x1_sync_reg <= 1'b0;
      x1_prev_reg <= 1'b0;
    end else if (ce) begin
      x1_meta_reg <= osc_input_pin;
      x1_sync_reg <= x1_meta_reg;
      x1_prev_reg <= x1_sync_reg;
    end
  end

  assign osc_en = sec_reg[SEC_START_BIT] | ctrl_reg[CTRL_EXTCLK_BIT]; // RULE4 RULE5
  // A disabled oscillator produces no edges, which is what starves the flag
  assign osc_edge = osc_en & x1_sync_reg & ~x1_prev_reg; // RULE3
  assign timed_out = (idle_reg >= IDLE_LIMIT); // RULE22

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_reg <= '0;
    end else if (ce) begin
      if (osc_edge) begin
        idle_reg <= '0;
      end else if (!timed_out) begin
        idle_reg <= IDLE_W'(idle_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_state_reg <= OSC_STOPPED;
      edge_cnt_reg <= 6'h00;
      osc_running_flag <= 1'b0;
    end else if (ce) begin
      case (osc_state_reg)
        OSC_STOPPED: begin
          if (osc_edge) begin
            edge_cnt_reg <= 6'h01;
            osc_state_reg <= OSC_STARTING;
          end
        end
        OSC_STARTING: begin
          if (timed_out) begin
            edge_cnt_reg <= 6'h00;
            osc_state_reg <= OSC_STOPPED;
          end else if (osc_edge) begin
            if (edge_cnt_reg == OSC_RUN_LAST) begin
              osc_running_flag <= 1'b1; // RULE1
              osc_state_reg <= OSC_RUNNING;
            end
            edge_cnt_reg <= 6'(edge_cnt_reg + 6'h01);
          end
        end
        OSC_RUNNING: begin
          if (timed_out) begin
            osc_running_flag <= 1'b0; // RULE2
            edge_cnt_reg <= 6'h00;
            osc_state_reg <= OSC_STOPPED;
          end
        end
        default: begin
          osc_state_reg <= OSC_STOPPED;
        end
      endcase
    end
  end

  // Nothing here looks at supply state, so counting goes on from backup
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_reg <= '0;
      sec_tick <= 1'b0;
    end else if (ce) begin
      sec_tick <= 1'b0;
      if (osc_edge) begin
        if (pre_reg == PRE_LAST) begin
          pre_reg <= '0;
          sec_tick <= 1'b1; // RULE20
        end else begin
          pre_reg <= PRE_W'(pre_reg + 1'b1);
        end
      end
    end
  end

  rot_month_len u_month_len (
    .month(mth_reg[4:0]),
    .year(year_reg),
    .leap(leap),
    .max_date(max_date)
  );

  assign sec_wrap = (sec_reg[6:0] == SEC_LAST);
  assign min_wrap = (min_reg[6:0] == MIN_LAST);
  assign date_wrap = (date_reg[5:0] == max_date); // RULE8
  assign mth_wrap = (mth_reg[4:0] == MTH_LAST);

  always_comb begin
    hour_next = hour_reg;
    day_carry = 1'b0;
    if (hour_reg[HOUR_FMT12_BIT]) begin // RULE14
      if (hour_reg[4:0] == HOUR12_TWELVE) begin
        hour_next[4:0] = HOUR12_ONE; // RULE15
      end else if (hour_reg[4:0] == HOUR12_ELEVEN) begin
        hour_next[4:0] = HOUR12_TWELVE;
        hour_next[HOUR_PM_BIT] = ~hour_reg[HOUR_PM_BIT];
        day_carry = hour_reg[HOUR_PM_BIT]; // RULE10
      end else begin
        hour_next[4:0] = 5'(bcd_inc({3'h0, hour_reg[4:0]}));
      end
    end else begin
      if (hour_reg[5:0] == HOUR24_LAST) begin
        hour_next[5:0] = HOUR24_FIRST; // RULE10
        day_carry = 1'b1;
      end else begin
        hour_next[5:0] = 6'(bcd_inc({2'h0, hour_reg[5:0]})); // RULE15
      end
    end
  end

  always_comb begin
    wr_hit_sec = 1'b0;
    wr_hit_min = 1'b0;
    wr_hit_hour = 1'b0;
    wr_hit_day_of_week_value = 1'b0;
    wr_hit_date = 1'b0;
    wr_hit_mth = 1'b0;
    wr_hit_year = 1'b0;
    wr_hit_ctrl = 1'b0;
    if (wr_strobe) begin
      if (ptr_reg == ADDR_SEC) begin
        wr_hit_sec = 1'b1;
      end else if (ptr_reg == ADDR_MIN) begin
        wr_hit_min = 1'b1;
      end else if (ptr_reg == ADDR_HOUR) begin
        wr_hit_hour = 1'b1;
      end else if (ptr_reg == ADDR_DAY_OF_WEEK_VALUE) begin
        wr_hit_day_of_week_value = 1'b1;
      end else if (ptr_reg == ADDR_DATE) begin
        wr_hit_date = 1'b1;
      end else if (ptr_reg == ADDR_MTH) begin
        wr_hit_mth = 1'b1;
      end else if (ptr_reg == ADDR_YEAR) begin
        wr_hit_year = 1'b1;
      end else if (ptr_reg == ADDR_CTRL) begin
        wr_hit_ctrl = 1'b1;
      end
    end
  end

  // A host write in the same cycle as a tick wins for the written register
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_reg <= SEC_RST;
      min_reg <= MIN_RST;
      hour_reg <= HOUR_RST;
      day_of_week_value_reg <= DAY_OF_WEEK_VALUE_RST[3:0];
      date_reg <= DATE_RST;
      mth_reg <= MTH_RST;
      year_reg <= YEAR_RST;
    end else if (ce) begin
      if (sec_tick) begin
        sec_reg[6:0] <= sec_wrap ? 7'h00 : 7'(bcd_inc({1'b0, sec_reg[6:0]})); // RULE16
        if (sec_wrap) begin
          min_reg[6:0] <= min_wrap ? 7'h00 : 7'(bcd_inc({1'b0, min_reg[6:0]})); // RULE17
          if (min_wrap) begin
            hour_reg <= hour_next;
            if (day_carry) begin
              if (day_of_week_value_reg[2:0] == DAY_OF_WEEK_VALUE_LAST) begin
                day_of_week_value_reg[2:0] <= DAY_OF_WEEK_VALUE_FIRST; // RULE11
              end else begin
                day_of_week_value_reg[2:0] <= 3'(day_of_week_value_reg[2:0] + 3'h1);
              end
              if (date_wrap) begin
                date_reg[5:0] <= DATE_FIRST; // RULE9
                if (mth_wrap) begin
                  mth_reg[4:0] <= MTH_FIRST; // RULE12
                  year_reg <= (year_reg == YEAR_LAST) ? 8'h00 : bcd_inc(year_reg); // RULE13
                end else begin
                  mth_reg[4:0] <= 5'(bcd_inc({3'h0, mth_reg[4:0]}));
                end
              end else begin
                date_reg[5:0] <= 6'(bcd_inc({2'h0, date_reg[5:0]}));
              end
            end
          end
        end
      end
      // Out-of-range BCD loads are stored as given and count undefined
      if (wr_hit_sec) sec_reg <= wr_data & SEC_WMASK; // RULE4 RULE7
      if (wr_hit_min) min_reg <= wr_data & MIN_WMASK; // RULE17
      if (wr_hit_hour) hour_reg <= wr_data & HOUR_WMASK; // RULE14
      if (wr_hit_day_of_week_value) day_of_week_value_reg <= wr_data[3:0];
      if (wr_hit_date) date_reg <= wr_data & DATE_WMASK;
      if (wr_hit_mth) mth_reg <= wr_data & MTH_WMASK;
      if (wr_hit_year) year_reg <= wr_data & YEAR_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (ce && wr_hit_ctrl) begin
      ctrl_reg <= wr_data & CTRL_WMASK; // RULE5
    end
  end

  // Any weekday write clears the power-loss flag; a coincident loss wins
  always_ff @(posedge clk) begin
    if (rst) begin
      pfail_reg <= 1'b0;
    end else if (ce) begin
      if (pwr_lost) begin
        pfail_reg <= 1'b1;
      end else if (wr_hit_day_of_week_value) begin
        pfail_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    live.sec = sec_reg;
    live.min = {1'b0, min_reg[6:0]}; // RULE21
    live.hour = {1'b0, hour_reg[6:0]};
    live.day_of_week_value = {2'b00, osc_running_flag, pfail_reg, day_of_week_value_reg};
    live.date = {2'b00, date_reg[5:0]};
    live.mth = {2'b00, leap, mth_reg[4:0]};
    live.year = year_reg;
    live.ctrl = ctrl_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= 5'h00;
    end else if (ce) begin
      if (ptr_load) begin
        ptr_reg <= ptr_addr;
      end else if (rd_strobe || wr_strobe) begin
        ptr_reg <= 5'(ptr_reg + 5'h01);
      end
    end
  end

  // Reads come from a frozen copy so a carry mid-transfer cannot tear the time
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_reg <= '0;
    end else if (ce) begin
      if (rd_begin || (rd_strobe && (ptr_reg == ADDR_TOP))) begin
        snap_reg <= live; // RULE18 RULE19
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (ce && rd_strobe) begin
      if (ptr_reg == ADDR_SEC) begin
        rd_data <= snap_reg.sec;
      end else if (ptr_reg == ADDR_MIN) begin
        rd_data <= snap_reg.min;
      end else if (ptr_reg == ADDR_HOUR) begin
        rd_data <= snap_reg.hour;
      end else if (ptr_reg == ADDR_DAY_OF_WEEK_VALUE) begin
        rd_data <= snap_reg.day_of_week_value;
      end else if (ptr_reg == ADDR_DATE) begin
        rd_data <= snap_reg.date;
      end else if (ptr_reg == ADDR_MTH) begin
        rd_data <= snap_reg.mth;
      end else if (ptr_reg == ADDR_YEAR) begin
        rd_data <= snap_reg.year;
      end else if (ptr_reg == ADDR_CTRL) begin
        rd_data <= snap_reg.ctrl;
      end else begin
        rd_data <= 8'h00; // RULE21
      end
    end
  end

endmodule
`default_nettype wire

// File: bench/rot_osc_model.sv
// Oscillator source model for the pin of the timekeeping core
`timescale 1ns/1ns
`default_nettype none
module rot_osc_model #(
  parameter int HALF_NS = 110
) (
  input wire logic en,  // Source running
  output logic pin      // Level into the oscillator pin
);
  // A stopped crystal stands still low; the offset keeps every change off a clk edge
  initial begin
    pin = 1'b0;
    #5;
    forever begin
      #(HALF_NS);
      pin = en ? !pin : 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: bench/rot_core_checker.sv
// Port-level assertions for the timekeeping core
`timescale 1ns/1ns
`default_nettype none
module rot_core_checker
  import rot_pkg::*;
#(
  parameter int OSC_FAIL_CYCLES = OSC_FAIL_CYCLES_DEF,
  parameter int EDGES_PER_SEC = OSC_FREQ_HZ
) (
  input wire logic clk,             // System clock
  input wire logic rst,             // Synchronous reset
  input wire logic ce,              // Clock enable
  input wire logic osc_input_pin,   // Oscillator pin
  input wire logic pwr_lost,        // Power loss pulse
  input wire logic ptr_load,        // Pointer load
  input wire logic [4:0] ptr_addr,  // Pointer value
  input wire logic rd_begin,        // Read transfer start
  input wire logic rd_strobe,       // Read byte
  input wire logic wr_strobe,       // Write byte
  input wire logic [7:0] wr_data,   // Write data
  input wire logic [7:0] rd_data,   // Read data
  input wire logic osc_running_flag, // Running status
  input wire logic sec_tick         // Second pulse
);
  logic [4:0] ptr_reg;
  logic [4:0] raddr_reg;
  logic rvld_reg;
  logic pin_reg;
  logic [15:0] idle_reg;
  logic [7:0] edges_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Shadow pointer, so each returned byte can be tied to its address
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= 5'h00;
      rvld_reg <= 1'b0;
    end else if (ce) begin
      rvld_reg <= rd_strobe;
      if (rd_strobe) begin
        raddr_reg <= ptr_reg;
      end
      if (ptr_load) begin
        ptr_reg <= ptr_addr;
      end else if (rd_strobe || wr_strobe) begin
        ptr_reg <= ptr_reg + 5'h01;
      end
    end
  end
  // Raw pin activity: edge count is an upper bound, idle count a lower bound, of what the gated logic sees
  always_ff @(posedge clk) begin
    pin_reg <= osc_input_pin;
    if (rst || pin_reg != osc_input_pin) begin
      idle_reg <= 16'h0000;
    end else if (idle_reg != 16'hFFFF) begin
      idle_reg <= idle_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || osc_running_flag) begin
      edges_reg <= 8'h00;
    end else if (!pin_reg && osc_input_pin && edges_reg != 8'hFF) begin
      edges_reg <= edges_reg + 8'h01;
    end
  end
  chk_run_edge_count: assert property ($rose(osc_running_flag) |-> edges_reg >= 8'h20)
    else $error("running flag rose before enough oscillator edges");
  chk_fail_timeout: assert property (idle_reg > 16'(OSC_FAIL_CYCLES + 8) |-> !osc_running_flag)
    else $error("running flag kept without oscillator edges");
  chk_tick_pulse: assert property (sec_tick |=> !sec_tick)
    else $error("second pulse wider than one cycle");
  chk_reserved_zero: assert property (rvld_reg && raddr_reg > ADDR_CTRL |-> rd_data == 8'h00)
    else $error("unmapped address returned nonzero");
  chk_min_layout: assert property (rvld_reg && raddr_reg == ADDR_MIN |->
    !rd_data[7] && rd_data[6:4] <= 3'h5 && rd_data[3:0] <= 4'h9)
    else $error("minutes byte out of layout");
  chk_sec_digits: assert property (rvld_reg && raddr_reg == ADDR_SEC |->
    rd_data[6:4] <= 3'h5 && rd_data[3:0] <= 4'h9)
    else $error("seconds digits out of range");
  chk_day_of_week_value_range: assert property (rvld_reg && raddr_reg == ADDR_DAY_OF_WEEK_VALUE |->
    rd_data[7:6] == 2'b00 && rd_data[2:0] != 3'h0)
    else $error("weekday byte out of range");
  chk_data_holds: assert property (!rd_strobe |=> $stable(rd_data))
    else $error("read data changed without a read");
  cover property ($rose(osc_running_flag));
  cover property (sec_tick);
  cover property (rvld_reg && raddr_reg > ADDR_CTRL);
endmodule
bind rot_core rot_core_checker #(
  .OSC_FAIL_CYCLES(OSC_FAIL_CYCLES),
  .EDGES_PER_SEC(EDGES_PER_SEC)
) u_chk (
  .clk(clk), .rst(rst), .ce(ce), .osc_input_pin(osc_input_pin), .pwr_lost(pwr_lost),
  .ptr_load(ptr_load), .ptr_addr(ptr_addr), .rd_begin(rd_begin), .rd_strobe(rd_strobe),
  .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data),
  .osc_running_flag(osc_running_flag), .sec_tick(sec_tick)
);
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the timekeeping core
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import rot_pkg::*;
;
  logic clk, rst, ce, pwr_lost, ptr_load, rd_begin, rd_strobe, wr_strobe, osc_en;
  logic [4:0] ptr_addr;
  logic [7:0] wr_data, rd_data;
  logic osc_pin, osc_running_flag, sec_tick;
  logic [7:0] rb [9];
  int failures, checks_done;
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  rot_osc_model #(.HALF_NS(110)) u_osc (.en(osc_en), .pin(osc_pin));
  // Short counts keep the run brief: 16-cycle fail timeout, 4 edges a second
  rot_core #(.OSC_FAIL_CYCLES(16), .EDGES_PER_SEC(4)) u_dut (
    .clk(clk), .rst(rst), .ce(ce), .osc_input_pin(osc_pin), .pwr_lost(pwr_lost),
    .ptr_load(ptr_load), .ptr_addr(ptr_addr), .rd_begin(rd_begin), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data),
    .osc_running_flag(osc_running_flag), .sec_tick(sec_tick));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic leap_of(input logic [7:0] y);
    if (y[4]) begin
      return y[3:0] == 4'h2 || y[3:0] == 4'h6;
    end
    return y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8;
  endfunction
  task automatic pulse_ptr(input logic [4:0] a);
    ptr_load <= 1'b1;
    ptr_addr <= a;
    @(posedge clk);
    ptr_load <= 1'b0;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    pulse_ptr(a);
    wr_strobe <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  // Without snap the transfer reuses the buffers of an earlier one
  task automatic rd_burst(input logic [4:0] a, input int n, input logic snap);
    pulse_ptr(a);
    rd_begin <= snap;
    @(posedge clk);
    rd_begin <= 1'b0;
    rd_strobe <= 1'b1;
    // Each byte is taken one edge after its strobe, once rd_data has settled
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      if (i == n - 1) begin
        rd_strobe <= 1'b0;
      end
      if (i > 0) begin
        rb[i - 1] = rd_data;
      end
    end
  endtask
  task automatic wait_until(input logic tick, input logic val);
    int k;
    k = 0;
    while ((tick ? sec_tick : osc_running_flag) !== val && k < 2000) begin
      @(posedge clk);
      k++;
    end
    check({7'h00, tick ? sec_tick : osc_running_flag}, {7'h00, val});
    if ((tick ? sec_tick : osc_running_flag) !== val) begin
      give_verdict();
    end
  endtask
  task automatic t_reset_values();
    logic [7:0] e [8];
    e = '{SEC_RST, MIN_RST, HOUR_RST, DAY_OF_WEEK_VALUE_RST, DATE_RST,
      MTH_RST | {2'b00, leap_of(YEAR_RST), 5'h00}, YEAR_RST, CTRL_RST};
    rd_burst(ADDR_SEC, 9, 1'b1);
    foreach (e[i]) begin
      check(rb[i], e[i]);
    end
    check(rb[8], 8'h00);
  endtask
  task automatic t_osc();
    osc_en <= 1'b1;
    repeat (300) @(posedge clk);
    check({7'h00, osc_running_flag}, 8'h00);
    wr_reg(ADDR_SEC, 8'h80);
    wait_until(1'b0, 1'b1);
    rd_burst(ADDR_DAY_OF_WEEK_VALUE, 1, 1'b1);
    check(rb[0] & 8'h20, 8'h20);
    wr_reg(ADDR_SEC, 8'h00);
    wait_until(1'b0, 1'b0);
    wr_reg(ADDR_CTRL, 8'h08);
    wait_until(1'b0, 1'b1);
    osc_en <= 1'b0;
    wait_until(1'b0, 1'b0);
    wr_reg(ADDR_CTRL, 8'h00);
    osc_en <= 1'b1;
  endtask
  task automatic t_regs();
    pwr_lost <= 1'b1;
    @(posedge clk);
    pwr_lost <= 1'b0;
    wr_reg(ADDR_MIN, 8'hC2);
    rd_burst(ADDR_MIN, 3, 1'b1);
    check(rb[0], 8'h42);
    check(rb[2], 8'h11);
    wr_reg(ADDR_DAY_OF_WEEK_VALUE, 8'hFD);
    wr_reg(ADDR_MIN, 8'h17);
    rd_burst(ADDR_MIN, 1, 1'b0);
    check(rb[0], 8'h42);
    rd_burst(ADDR_TOP, 5, 1'b0);
    check(rb[0], 8'h00);
    check(rb[2], 8'h17);
    check(rb[4], 8'h0D);
    // Clock enable low must swallow both the pointer load and the write
    ce <= 1'b0;
    wr_reg(ADDR_MIN, 8'h33);
    ce <= 1'b1;
    rd_burst(ADDR_MIN, 1, 1'b1);
    check(rb[0], 8'h17);
  endtask
  // Loads hh:59:59 on a stopped clock, restarts it and reads one tick later
  task automatic roll(input logic [7:0] h, wk, m, d, y, eh, ewk, em, ed, ey);
    logic [7:0] v [6];
    logic [7:0] e [7];
    v = '{8'h59, h, wk, d, m, y};
    e = '{8'h80, 8'h00, eh, ewk, ed, {2'b00, leap_of(ey), em[4:0]}, ey};
    wr_reg(ADDR_SEC, 8'h00);
    wait_until(1'b0, 1'b0);
    pulse_ptr(ADDR_MIN);
    foreach (v[i]) begin
      wr_strobe <= 1'b1;
      wr_data <= v[i];
      @(posedge clk);
    end
    wr_strobe <= 1'b0;
    wr_reg(ADDR_SEC, 8'hD9);
    wait_until(1'b1, 1'b1);
    rd_burst(ADDR_SEC, 7, 1'b1);
    // Running bit is masked: the flag needs more edges than one second here
    foreach (e[i]) begin
      check(i == 3 ? rb[i] & 8'hDF : rb[i], e[i]);
    end
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pwr_lost = 1'b0;
    ptr_load = 1'b0;
    ptr_addr = 5'h00;
    rd_begin = 1'b0;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    wr_data = 8'h00;
    osc_en = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_osc();
    t_regs();
    roll(8'h23, 8'h07, 8'h01, 8'h31, 8'h25, 8'h00, 8'h01, 8'h02, 8'h01, 8'h25);
    roll(8'h71, 8'h03, 8'h02, 8'h28, 8'h23, 8'h52, 8'h04, 8'h03, 8'h01, 8'h23);
    roll(8'h51, 8'h05, 8'h02, 8'h28, 8'h24, 8'h72, 8'h05, 8'h02, 8'h28, 8'h24);
    roll(8'h23, 8'h02, 8'h02, 8'h28, 8'h24, 8'h00, 8'h03, 8'h02, 8'h29, 8'h24);
    roll(8'h23, 8'h04, 8'h02, 8'h29, 8'h24, 8'h00, 8'h05, 8'h03, 8'h01, 8'h24);
    roll(8'h23, 8'h06, 8'h04, 8'h30, 8'h25, 8'h00, 8'h07, 8'h05, 8'h01, 8'h25);
    roll(8'h23, 8'h03, 8'h03, 8'h30, 8'h25, 8'h00, 8'h04, 8'h03, 8'h31, 8'h25);
    roll(8'h23, 8'h01, 8'h12, 8'h31, 8'h99, 8'h00, 8'h02, 8'h01, 8'h01, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
